// ### src/mrw_pkg.sv
// Purpose: Constants for the module reset and wake sequencer.
// Assumes: 200 MHz clock, cycles per millisecond derived from it.
// Notes: Times are kept in their own unit, counts derived here.
package mrw_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PER_MS = CLK_HZ / 1000;
  localparam int RST_ASSERT_MS = 20;
  localparam int RESTART_MS = 2000;
  localparam int FAST_CLK_HZ = 26_000_000;
  localparam int SLOW_CLK_HZ = 32_768;
  // Half periods are rounded to the nearest whole clock cycle.
  localparam int FAST_HALF = (CLK_HZ + FAST_CLK_HZ) / (2 * FAST_CLK_HZ);
  localparam int SLOW_HALF = (CLK_HZ + SLOW_CLK_HZ) / (2 * SLOW_CLK_HZ);
  localparam int MS_W = 12;
  localparam int DIV_W = 16;
  localparam int FCLK_W = 4;
  localparam int SCLK_W = 12;
endpackage

// ### src/mrw_sequencer.sv
// Purpose: Reset, power hold and wake sequencing with two reference clock outputs.
// Assumes: All inputs synchronous to clk_i; reset pin and hold pin are active low.
// Notes: The fast clock output is the nearest divided rate reachable from clk_i.
// What this block does
// - Qualified reset with power hold low restarts directly, no off state.
// - Qualified reset with power hold high powers the device off when wake is low.
// - Restart after the reset falling edge lasts at least 2000 ms.
// - Wake high leaves off or sleep states.
// - No sleep or off state is entered while wake stays high.
// - Only a high wake level counts as a wake request.
// - Without wake, off is never left; a reset on rstn_i also loads off.
// - Two reference clocks, each enabled by host command.
`timescale 1ns/1ps
module mrw_sequencer #(
  parameter int RST_ASSERT_CYC = mrw_pkg::RST_ASSERT_MS * mrw_pkg::CLK_PER_MS,
  parameter int RESTART_CYC = mrw_pkg::RESTART_MS * mrw_pkg::CLK_PER_MS
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hard_reset_in_low_i,
  input wire logic power_hold_in_low_i,
  input wire logic wake_request_i,
  input wire logic sleep_request_i,
  input wire logic soft_off_request_i,
  input wire logic fast_clk_enable_i,
  input wire logic slow_clk_enable_i,
  output logic active_o,
  output logic powered_o,
  output logic restarting_o,
  output logic fast_reference_clock_out_o,
  output logic slow_reference_clock_out_o
);

  typedef enum logic [1:0] {MRW_OFF, MRW_BOOT, MRW_ACTIVE, MRW_SLEEP} mrw_state_e;

  typedef struct packed {
    mrw_state_e st;
    logic [31:0] rst_cnt;
    logic [31:0] boot_cnt;
    logic [mrw_pkg::FCLK_W-1:0] fdiv;
    logic [mrw_pkg::SCLK_W-1:0] sdiv;
    logic fclk;
    logic sclk;
    logic active;
    logic powered;
    logic restarting;
  } mrw_state_s;

  mrw_state_s cur_ff;
  mrw_state_s nxt_cur;
  logic rst_qual;

  always_comb begin
    nxt_cur = cur_ff;
    rst_qual = 1'b0;
    // Low-duration filter on the reset pin.
    if (!hard_reset_in_low_i) begin
      if (cur_ff.rst_cnt < 32'(RST_ASSERT_CYC)) begin
        nxt_cur.rst_cnt = cur_ff.rst_cnt + 32'h1;
      end
    end else begin
      nxt_cur.rst_cnt = '0;
      rst_qual = (cur_ff.rst_cnt >= 32'(RST_ASSERT_CYC)) && cur_ff.powered;
    end
    case (cur_ff.st)
      MRW_OFF: begin
        // Only a high wake level leaves off.
        if (wake_request_i) begin
          nxt_cur.st = MRW_BOOT;
          nxt_cur.boot_cnt = '0;
        end
      end
      MRW_BOOT: begin
        // Restart period counted from the reset falling edge; release preloads the assert time.
        if (cur_ff.boot_cnt < 32'(RESTART_CYC)) begin
          nxt_cur.boot_cnt = cur_ff.boot_cnt + 32'h1;
        end else begin
          nxt_cur.st = MRW_ACTIVE;
        end
      end
      MRW_ACTIVE: begin
        // Sleep and soft off are held off while wake is high.
        if (!wake_request_i && (soft_off_request_i || power_hold_in_low_i)) begin
          nxt_cur.st = MRW_OFF;
        end else if (!wake_request_i && sleep_request_i) begin
          nxt_cur.st = MRW_SLEEP;
        end
      end
      MRW_SLEEP: begin
        if (wake_request_i) begin
          nxt_cur.st = MRW_ACTIVE;
        end
      end
      default: nxt_cur.st = MRW_OFF;
    endcase
    if (rst_qual) begin
      if (!power_hold_in_low_i) begin
        nxt_cur.st = MRW_BOOT;
        nxt_cur.boot_cnt = 32'(RST_ASSERT_CYC);
      end else if (!wake_request_i) begin
        nxt_cur.st = MRW_OFF;
      end
    end
    // Reference clock dividers, each gated by its enable.
    if (fast_clk_enable_i && nxt_cur.st != MRW_OFF) begin
      if (cur_ff.fdiv >= mrw_pkg::FCLK_W'(mrw_pkg::FAST_HALF - 1)) begin
        nxt_cur.fdiv = '0;
        nxt_cur.fclk = ~cur_ff.fclk;
      end else begin
        nxt_cur.fdiv = cur_ff.fdiv + 1'b1;
      end
    end else begin
      nxt_cur.fdiv = '0;
      nxt_cur.fclk = 1'b0;
    end
    if (slow_clk_enable_i && nxt_cur.st != MRW_OFF) begin
      if (cur_ff.sdiv >= mrw_pkg::SCLK_W'(mrw_pkg::SLOW_HALF - 1)) begin
        nxt_cur.sdiv = '0;
        nxt_cur.sclk = ~cur_ff.sclk;
      end else begin
        nxt_cur.sdiv = cur_ff.sdiv + 1'b1;
      end
    end else begin
      nxt_cur.sdiv = '0;
      nxt_cur.sclk = 1'b0;
    end
    nxt_cur.active = (nxt_cur.st == MRW_ACTIVE);
    nxt_cur.powered = (nxt_cur.st != MRW_OFF);
    nxt_cur.restarting = (nxt_cur.st == MRW_BOOT);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cur_ff <= '{st: MRW_OFF, rst_cnt: '0, boot_cnt: '0, fdiv: '0,
                  sdiv: '0, fclk: 1'b0, sclk: 1'b0, active: 1'b0, powered: 1'b0,
                  restarting: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign active_o = cur_ff.active;
  assign powered_o = cur_ff.powered;
  assign restarting_o = cur_ff.restarting;
  assign fast_reference_clock_out_o = cur_ff.fclk;
  assign slow_reference_clock_out_o = cur_ff.sclk;

  property p_restart_low;
    @(posedge clk_i) disable iff (!rstn_i)
      (rst_qual && !power_hold_in_low_i) |=> (cur_ff.st == MRW_BOOT);
  endproperty
  a_restart_low: assert property (p_restart_low) else $error("No restart on reset.");

  property p_off_high;
    @(posedge clk_i) disable iff (!rstn_i)
      (rst_qual && power_hold_in_low_i && !wake_request_i) |=> !powered_o;
  endproperty
  a_off_high: assert property (p_off_high) else $error("No power off on reset.");

  property p_boot_min;
    @(posedge clk_i) disable iff (!rstn_i)
      (cur_ff.st == MRW_BOOT && cur_ff.boot_cnt < 32'(RESTART_CYC)) |=> !active_o;
  endproperty
  a_boot_min: assert property (p_boot_min) else $error("Active too early.");

  property p_wake_off;
    @(posedge clk_i) disable iff (!rstn_i)
      (cur_ff.st == MRW_OFF && wake_request_i && !rst_qual) |=> restarting_o;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("Wake ignored in off.");

  property p_wake_sleep;
    @(posedge clk_i) disable iff (!rstn_i)
      (cur_ff.st == MRW_SLEEP && wake_request_i && !rst_qual) |=> active_o;
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("Wake ignored in sleep.");

  property p_no_off_wake;
    @(posedge clk_i) disable iff (!rstn_i)
      (powered_o && wake_request_i && $past(wake_request_i)) |=> powered_o;
  endproperty
  a_no_off_wake: assert property (p_no_off_wake) else $error("Off while wake high.");

  property p_stay_off;
    @(posedge clk_i) disable iff (!rstn_i)
      (!powered_o && !wake_request_i) |=> !powered_o;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("Left off without wake.");

  property p_short_pulse;
    @(posedge clk_i) disable iff (!rstn_i)
      (hard_reset_in_low_i && cur_ff.rst_cnt < 32'(RST_ASSERT_CYC)) |-> !rst_qual;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("Short pulse taken.");

  property p_clk_gate;
    @(posedge clk_i) disable iff (!rstn_i)
      !fast_clk_enable_i |=> !fast_reference_clock_out_o;
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("Fast clock not gated.");

  property p_slow_gate;
    @(posedge clk_i) disable iff (!rstn_i)
      !slow_clk_enable_i |=> !slow_reference_clock_out_o;
  endproperty
  a_slow_gate: assert property (p_slow_gate) else $error("Slow clock not gated.");

  property p_off_quiet;
    @(posedge clk_i) disable iff (!rstn_i)
      !powered_o |-> (!fast_reference_clock_out_o && !slow_reference_clock_out_o);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("Clock out while off.");

  c_restart: cover property (@(posedge clk_i) disable iff (!rstn_i)
    rst_qual && !power_hold_in_low_i);
  c_poweroff: cover property (@(posedge clk_i) disable iff (!rstn_i)
    rst_qual && power_hold_in_low_i);
  c_sleep: cover property (@(posedge clk_i) disable iff (!rstn_i)
    cur_ff.st == MRW_SLEEP && wake_request_i);
  c_wake_boot: cover property (@(posedge clk_i) disable iff (!rstn_i)
    cur_ff.st == MRW_OFF && wake_request_i);
endmodule

// ### verification/mrw_host.sv
// Purpose: Host model driving the reset pin, the power hold pin and the wake line.
// Assumes: Pins change only at the rising edge of clk_i.
// Notes: Reset idles high by pull-up, hold and wake idle low by pull-down.
`timescale 1ns/1ps
module mrw_host (
  input wire logic clk_i,
  output logic hard_reset_in_low_o,
  output logic power_hold_in_low_o,
  output logic wake_request_o
);
  initial begin
    hard_reset_in_low_o = 1'b1;
    power_hold_in_low_o = 1'b0;
    wake_request_o = 1'b0;
  end
  // Holds the reset pin low for n cycles.
  task automatic reset_pulse(input int n);
    hard_reset_in_low_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    hard_reset_in_low_o <= 1'b1;
  endtask
  // Wake stays at its level until the bench changes it.
  task automatic set_wake(input logic v);
    wake_request_o <= v;
  endtask
  // Hold low keeps power, high lets the device turn off.
  task automatic set_hold(input logic v);
    power_hold_in_low_o <= v;
  endtask
endmodule

// ### verification/tb.sv
// Purpose: Self-checking bench for the reset and wake sequencer.
// Assumes: Shortened counts of 8 and 40 cycles.
// Notes: Checks are made at the falling edge.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb;
  localparam int RA = 8;
  localparam int RS = 40;
  logic clk_i = 1'b0;
  logic rstn_i;
  logic slp;
  logic sof;
  logic fen;
  logic sen;
  logic rpin, hpin, wpin, act, pwr, rst, fck, sck;
  int failures = 0;
  int cmp_count = 0;
  always #2.5 clk_i = ~clk_i;
  mrw_host host (.clk_i(clk_i), .hard_reset_in_low_o(rpin), .power_hold_in_low_o(hpin),
    .wake_request_o(wpin));
  mrw_sequencer #(.RST_ASSERT_CYC(RA), .RESTART_CYC(RS)) dut (.clk_i(clk_i),
    .rstn_i(rstn_i), .hard_reset_in_low_i(rpin), .power_hold_in_low_i(hpin),
    .wake_request_i(wpin), .sleep_request_i(slp), .soft_off_request_i(sof),
    .fast_clk_enable_i(fen), .slow_clk_enable_i(sen), .active_o(act), .powered_o(pwr),
    .restarting_o(rst), .fast_reference_clock_out_o(fck), .slow_reference_clock_out_o(sck));
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_act(output int n);
    n = 0;
    while (act !== 1'b1 && n < 4 * RS) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic t_wake();
    int n;
    @(posedge clk_i);
    host.set_wake(1'b1);
    repeat (2) @(negedge clk_i);
    `CHK("restarting", 1'b1, rst)
    wait_act(n);
    `CHK("boot long", 1'b1, n >= RS - 2 && n < 2 * RS)
    `CHK("powered", 1'b1, pwr)
    @(posedge clk_i);
    host.set_wake(1'b0);
    $display("wake test done");
  endtask
  task automatic t_short();
    @(posedge clk_i);
    host.reset_pulse(RA - 5);
    repeat (4) @(negedge clk_i);
    `CHK("short active", 1'b1, act)
    `CHK("short restart", 1'b0, rst)
    $display("short pulse test done");
  endtask
  task automatic t_restart();
    int n;
    @(posedge clk_i);
    host.reset_pulse(RA + 2);
    repeat (2) @(negedge clk_i);
    `CHK("restarting", 1'b1, rst)
    `CHK("powered", 1'b1, pwr)
    `CHK("active", 1'b0, act)
    wait_act(n);
    `CHK("restart span", 1'b1, RA + 3 + n >= RS && n < 2 * RS)
    $display("restart test done");
  endtask
  task automatic t_clocks();
    int f, s;
    for (int ph = 0; ph < 2; ph++) begin
      f = 0;
      s = 0;
      @(posedge clk_i);
      fen <= (ph == 0);
      sen <= (ph == 0);
      repeat (12) @(negedge clk_i);
      repeat (3100) begin
        logic pf, ps;
        pf = fck;
        ps = sck;
        @(negedge clk_i);
        f += (fck !== pf);
        s += (sck !== ps);
      end
      `CHK("fast toggles", ph == 0, f > 700 && f < 900)
      `CHK("slow toggles", ph == 0, s == 1)
      `CHK("fast idle", 1'b1, ph == 0 || f == 0)
    end
    $display("clock test done");
  endtask
  task automatic t_block();
    @(posedge clk_i);
    host.set_wake(1'b1);
    host.set_hold(1'b1);
    slp <= 1'b1;
    sof <= 1'b1;
    host.reset_pulse(RA + 2);
    repeat (RS) @(negedge clk_i);
    `CHK("held awake", 1'b1, act)
    `CHK("held powered", 1'b1, pwr)
    @(posedge clk_i);
    host.set_wake(1'b0);
    slp <= 1'b0;
    repeat (5) @(negedge clk_i);
    `CHK("turned off", 1'b0, pwr)
    @(posedge clk_i);
    sof <= 1'b0;
    host.set_hold(1'b0);
    host.reset_pulse(RA + 2);
    repeat (RS + 5) @(negedge clk_i);
    `CHK("stays off", 1'b0, pwr)
    $display("block and off test done");
  endtask
  task automatic t_sleep_off();
    @(posedge clk_i);
    slp <= 1'b1;
    repeat (2) @(negedge clk_i);
    `CHK("sleeping", 1'b0, act)
    `CHK("sleep powered", 1'b1, pwr)
    @(posedge clk_i);
    slp <= 1'b0;
    host.set_wake(1'b1);
    repeat (2) @(negedge clk_i);
    `CHK("woken", 1'b1, act)
    @(posedge clk_i);
    host.set_wake(1'b0);
    slp <= 1'b1;
    repeat (2) @(negedge clk_i);
    @(posedge clk_i);
    slp <= 1'b0;
    host.set_hold(1'b1);
    host.reset_pulse(RA + 2);
    repeat (2) @(negedge clk_i);
    `CHK("reset off", 1'b0, pwr)
    @(posedge clk_i);
    host.set_hold(1'b0);
    $display("sleep and reset off test done");
  endtask
  initial begin
    rstn_i <= 1'b0;
    slp <= 1'b0;
    sof <= 1'b0;
    fen <= 1'b0;
    sen <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_wake();
    t_short();
    t_restart();
    t_clocks();
    t_block();
    t_wake();
    t_sleep_off();
    t_wake();
    stop_test();
  end
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule
